// file: logic/board_decode_powerfail.sv
// Board memory/I/O decode with power-fail interrupt routing and RAM protect
// Operation
// - Boot region ending at FFFFFH always selects the bank 1 device pair.
// - Two ROM banks, each a high-byte and low-byte device forming words.
// - Up to 256 KB total ROM, all devices one density set by parameter.
// - Asserted power-fail input raises the processor NMI when routing enabled.
// - Status latch bit 2 set to 1 lets power-fail interrupts through.
// - While memory protect is asserted every on-board RAM access is blocked.
// - On-board I/O devices decoded at their ports for I/O read and write.
// - Unassigned I/O ports are forwarded to the system bus as off-board.
// - Unpopulated expansion connector ranges are forwarded off-board.
`timescale 1ns/1ps
`include "board_decode_regs.svh"
module board_decode_powerfail import board_decode_pkg::*; #(
    parameter int ROM_DEV_ABITS = `ROM_DEV_ABITS_DEF,
    parameter logic [19:0] RAM_LIMIT = `RAM_LIMIT_DEF
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [19:0] cpu_addr,
    input wire logic cpu_bhe_n,
    input wire logic cpu_mem_rd,
    input wire logic cpu_mem_wr,
    input wire logic cpu_io_rd,
    input wire logic cpu_io_wr,
    input wire logic [7:0] cpu_io_wdata,
    input wire logic bus_ram_rd,
    input wire logic bus_ram_wr,
    input wire logic bus_bhe_n,
    input wire logic bus_a0,
    input wire logic exp0_present,
    input wire logic exp1_present,
    input wire logic nmi_route_en,
    input wire logic power_fail_irq_n,
    input wire logic mem_protect_n,
    input wire logic power_fail_sense_n,
    output logic [1:0] rom_bank_sel,
    output logic [1:0] rom_lane_en,
    output logic [ROM_DEV_ABITS-1:0] rom_dev_addr,
    output logic ram_local_rd,
    output logic ram_local_wr,
    output logic ram_bus_rd,
    output logic ram_bus_wr,
    output logic [1:0] ram_lane_en,
    output io_target_t io_target,
    output logic io_rd_strobe,
    output logic io_wr_strobe,
    output logic io_offboard,
    output logic nmi_req,
    output logic nmi_mask,
    output logic power_fail_seen
);
    localparam int BANK_BITS = ROM_DEV_ABITS + 1;
    localparam logic [19:0] BANK1_TAG = `MEM_TOP_ADDR >> BANK_BITS;
    localparam logic [19:0] BANK0_TAG = BANK1_TAG - 20'h00001;

    if (ROM_DEV_ABITS < `ROM_DEV_ABITS_MIN || ROM_DEV_ABITS > `ROM_DEV_ABITS_MAX) begin : g_bad_rom
        $error("board_decode_powerfail: ROM_DEV_ABITS out of range");
    end
    if (RAM_LIMIT > BANK0_TAG << BANK_BITS) begin : g_bad_ram
        $error("board_decode_powerfail: RAM window overlaps ROM");
    end

    // Bank hit, bit 1 for bank 1 and bit 0 for bank 0
    function automatic logic [1:0] rom_bank_hit(input logic [19:0] a);
        logic [19:0] tag;
        tag = a >> BANK_BITS;
        return {tag == BANK1_TAG, tag == BANK0_TAG};
    endfunction : rom_bank_hit

    // Byte lanes of a 16-bit word: {high, low}
    function automatic logic [1:0] lane_of(input logic bhe_n, input logic a0);
        return {~bhe_n, ~a0};
    endfunction : lane_of

    function automatic logic in_group(input logic [7:0] a, input logic [7:0] base, input logic [7:0] mask);
        return (a & mask) == base;
    endfunction : in_group

    function automatic io_target_t io_decode(input logic [7:0] a, input logic e0, input logic e1);
        io_target_t t;
        t = IO_OFFBOARD;
        if (in_group(a, `IO_PIC_BASE, `IO_PIC_MASK)) begin
            t = IO_PIC;
        end else if (in_group(a, `IO_PPI_BASE, `IO_PPI_MASK)) begin
            t = IO_PPI;
        end else if (in_group(a, `IO_TIMER_BASE, `IO_TIMER_MASK)) begin
            t = IO_TIMER;
        end else if (in_group(a, `IO_SERIAL_BASE, `IO_SERIAL_MASK)) begin
            t = IO_SERIAL;
        end else if (a[0] && a >= `IO_STATUS_LO && a <= `IO_STATUS_HI) begin
            t = IO_STATUS;
        end else if (in_group(a, `IO_EXP0_BASE, `IO_EXP_WORD_MASK)
                     || in_group(a, `IO_EXP0_BASE | `IO_EXP_BYTE_BASE, `IO_EXP_BYTE_MASK)) begin
            t = e0 ? IO_EXP0 : IO_OFFBOARD;
        end else if (in_group(a, `IO_EXP1_BASE, `IO_EXP_WORD_MASK)
                     || in_group(a, `IO_EXP1_BASE | `IO_EXP_BYTE_BASE, `IO_EXP_BYTE_MASK)) begin
            t = e1 ? IO_EXP1 : IO_OFFBOARD;
        end
        return t;
    endfunction : io_decode

    // Supply pins are asynchronous to the board clock
    logic [2:0] pins_sync;
    pin_sync3 #(
        .WIDTH(3),
        .RESET_VAL(3'h7)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_in({power_fail_irq_n, mem_protect_n, power_fail_sense_n}),
        .pin_out(pins_sync)
    );
    logic pf_irq, protect, pf_sense;
    assign pf_irq = ~pins_sync[2];
    assign protect = ~pins_sync[1];
    assign pf_sense = ~pins_sync[0];

    // ROM decode group
    logic [1:0] rom_bank_sel_reg, rom_bank_sel_next;
    logic [1:0] rom_lane_reg, rom_lane_next;
    logic [ROM_DEV_ABITS-1:0] rom_addr_reg, rom_addr_next;

    always_comb begin
        rom_bank_sel_next = 2'h0;
        rom_lane_next = 2'h0;
        rom_addr_next = cpu_addr[ROM_DEV_ABITS:1];
        if (cpu_mem_rd) begin
            rom_bank_sel_next = rom_bank_hit(cpu_addr);
            // Devices of the pair enabled per byte lane: both for a word read, one for a byte read
            if (rom_bank_sel_next != 2'h0) begin
                rom_lane_next = lane_of(cpu_bhe_n, cpu_addr[0]);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rom_bank_sel_reg <= 2'h0;
            rom_lane_reg <= 2'h0;
            rom_addr_reg <= '0;
        end else begin
            rom_bank_sel_reg <= rom_bank_sel_next;
            rom_lane_reg <= rom_lane_next;
            rom_addr_reg <= rom_addr_next;
        end
    end

    // RAM decode group; one inhibit term kills both lanes at once so no half word lands
    logic ram_lrd_reg, ram_lwr_reg, ram_brd_reg, ram_bwr_reg;
    logic ram_lrd_next, ram_lwr_next, ram_brd_next, ram_bwr_next;
    logic [1:0] ram_lane_reg, ram_lane_next;
    logic local_hit;

    always_comb begin
        local_hit = cpu_addr < RAM_LIMIT;
        ram_lrd_next = cpu_mem_rd && local_hit && !protect;
        ram_lwr_next = cpu_mem_wr && local_hit && !protect;
        ram_brd_next = bus_ram_rd && !protect;
        ram_bwr_next = bus_ram_wr && !protect;
        ram_lane_next = 2'h0;
        if (ram_lrd_next || ram_lwr_next) begin
            ram_lane_next = lane_of(cpu_bhe_n, cpu_addr[0]);
        end else if (ram_brd_next || ram_bwr_next) begin
            ram_lane_next = lane_of(bus_bhe_n, bus_a0);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ram_lrd_reg <= 1'b0;
            ram_lwr_reg <= 1'b0;
            ram_brd_reg <= 1'b0;
            ram_bwr_reg <= 1'b0;
            ram_lane_reg <= 2'h0;
        end else begin
            ram_lrd_reg <= ram_lrd_next;
            ram_lwr_reg <= ram_lwr_next;
            ram_brd_reg <= ram_brd_next;
            ram_bwr_reg <= ram_bwr_next;
            ram_lane_reg <= ram_lane_next;
        end
    end

    // I/O decode and status latch group
    io_target_t io_target_reg, io_target_next;
    logic io_rd_reg, io_rd_next, io_wr_reg, io_wr_next, io_off_reg, io_off_next;
    logic nmi_mask_reg, nmi_mask_next, nmi_reg, nmi_next, pf_seen_reg, pf_seen_next;

    always_comb begin
        io_target_next = IO_OFFBOARD;
        io_rd_next = 1'b0;
        io_wr_next = 1'b0;
        io_off_next = 1'b0;
        nmi_mask_next = nmi_mask_reg;
        if (cpu_io_rd || cpu_io_wr) begin
            io_target_next = io_decode(cpu_addr[7:0], exp0_present, exp1_present);
            io_rd_next = cpu_io_rd;
            io_wr_next = cpu_io_wr;
            io_off_next = io_target_next == IO_OFFBOARD;
            if (cpu_io_wr && io_target_next == IO_STATUS) begin
                nmi_mask_next = cpu_io_wdata[`NMI_MASK_BIT];
            end
        end
        nmi_next = pf_irq && nmi_route_en && nmi_mask_reg;
        pf_seen_next = pf_sense;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            io_target_reg <= IO_OFFBOARD;
            io_rd_reg <= 1'b0;
            io_wr_reg <= 1'b0;
            io_off_reg <= 1'b0;
            nmi_mask_reg <= `NMI_MASK_RESET;
            nmi_reg <= 1'b0;
            pf_seen_reg <= 1'b0;
        end else begin
            io_target_reg <= io_target_next;
            io_rd_reg <= io_rd_next;
            io_wr_reg <= io_wr_next;
            io_off_reg <= io_off_next;
            nmi_mask_reg <= nmi_mask_next;
            nmi_reg <= nmi_next;
            pf_seen_reg <= pf_seen_next;
        end
    end

    assign rom_bank_sel = rom_bank_sel_reg;
    assign rom_lane_en = rom_lane_reg;
    assign rom_dev_addr = rom_addr_reg;
    assign ram_local_rd = ram_lrd_reg;
    assign ram_local_wr = ram_lwr_reg;
    assign ram_bus_rd = ram_brd_reg;
    assign ram_bus_wr = ram_bwr_reg;
    assign ram_lane_en = ram_lane_reg;
    assign io_target = io_target_reg;
    assign io_rd_strobe = io_rd_reg;
    assign io_wr_strobe = io_wr_reg;
    assign io_offboard = io_off_reg;
    assign nmi_req = nmi_reg;
    assign nmi_mask = nmi_mask_reg;
    assign power_fail_seen = pf_seen_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_boot_bank1: assert property (cpu_mem_rd && cpu_addr >= `BOOT_BASE_ADDR |=> rom_bank_sel == 2'h2)
        else $error("boot region did not select bank 1");
    a_word_lanes: assert property (cpu_mem_rd && rom_bank_hit(cpu_addr) != 2'h0 && !cpu_bhe_n && !cpu_addr[0]
        |=> rom_lane_en == 2'h3)
        else $error("word read did not enable both devices");
    a_bank0_range: assert property (cpu_mem_rd && (cpu_addr >> BANK_BITS) == BANK0_TAG
        |=> rom_bank_sel == 2'h1 && rom_dev_addr == $past(cpu_addr[ROM_DEV_ABITS:1]))
        else $error("bank 0 decode or device address wrong");
    a_nmi_route: assert property (pf_irq && nmi_route_en && nmi_mask |=> nmi_req)
        else $error("power fail did not raise nmi");
    a_nmi_masked: assert property (!nmi_mask || !nmi_route_en |=> !nmi_req)
        else $error("nmi passed while masked or unrouted");
    a_mask_load: assert property (cpu_io_wr && io_decode(cpu_addr[7:0], exp0_present, exp1_present) == IO_STATUS
        |=> nmi_mask == $past(cpu_io_wdata[`NMI_MASK_BIT]))
        else $error("status latch write did not load mask");
    a_protect_block: assert property (protect |=> !ram_local_rd && !ram_local_wr && !ram_bus_rd && !ram_bus_wr)
        else $error("ram access while protected");
    a_bus_write: assert property (bus_ram_wr && !protect |=> ram_bus_wr && ram_lane_en == $past(lane_of(bus_bhe_n, bus_a0))
        || ram_local_rd || ram_local_wr)
        else $error("unprotected bus write dropped");
    a_io_pic: assert property (cpu_io_rd && cpu_addr[7:0] == `IO_PIC_BASE |=> io_target == IO_PIC && io_rd_strobe)
        else $error("pic port not decoded");
    a_io_offboard: assert property (cpu_io_rd && cpu_addr[7:0] == 8'h00 |=> io_offboard && io_target == IO_OFFBOARD)
        else $error("unassigned port not sent off-board");
    a_exp_absent: assert property ((cpu_io_rd || cpu_io_wr) && cpu_addr[7:4] == 4'hA && !exp0_present
        |=> io_offboard)
        else $error("empty connector range not off-board");

    c_boot_fetch: cover property (cpu_mem_rd && cpu_addr == `MEM_TOP_ADDR ##1 rom_bank_sel == 2'h2);
    c_nmi_raise: cover property (!nmi_req ##1 nmi_req);
    c_protect_write: cover property (cpu_mem_wr && local_hit && protect);
    c_exp_present: cover property (io_target == IO_EXP1);
endmodule : board_decode_powerfail

// file: shared/board_decode_regs.svh
// Address map constants for the board decode and power-fail block
`ifndef BOARD_DECODE_REGS_SVH
`define BOARD_DECODE_REGS_SVH

// Top of the 1 MB memory space and the boot region below it
`define MEM_TOP_ADDR 20'hFFFFF
`define BOOT_BASE_ADDR 20'hFFFF0

// Supported device address widths: 8 KB to 64 KB per device
`define ROM_DEV_ABITS_MIN 13
`define ROM_DEV_ABITS_MAX 16
`define ROM_DEV_ABITS_DEF 13

// On-board RAM window seen by the local processor (below this limit)
`define RAM_LIMIT_DEF 20'h20000

// I/O port groups, upper bits compared after masking the low bits
`define IO_PIC_BASE 8'hC0
`define IO_PIC_MASK 8'hF9
`define IO_PPI_BASE 8'hC8
`define IO_PPI_MASK 8'hF9
`define IO_TIMER_BASE 8'hD0
`define IO_TIMER_MASK 8'hF9
`define IO_SERIAL_BASE 8'hD8
`define IO_SERIAL_MASK 8'hF9
`define IO_STATUS_LO 8'hC9
`define IO_STATUS_HI 8'hDF
`define IO_EXP0_BASE 8'hA0
`define IO_EXP1_BASE 8'h80
`define IO_EXP_WORD_MASK 8'hF0
`define IO_EXP_BYTE_BASE 8'h10
`define IO_EXP_BYTE_MASK 8'hF1

// Reset value of the interrupt mask: blocked until software opens it
`define NMI_MASK_RESET 1'b0
`define NMI_MASK_BIT 2

`endif

// file: shared/board_decode_pkg.sv
// Types shared by the board decode and power-fail block
package board_decode_pkg;
    typedef enum logic [2:0] {
        IO_OFFBOARD,
        IO_PIC,
        IO_PPI,
        IO_TIMER,
        IO_SERIAL,
        IO_STATUS,
        IO_EXP0,
        IO_EXP1
    } io_target_t;
endpackage : board_decode_pkg

// file: logic/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
    logic [WIDTH-1:0] out_next;

    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync3: WIDTH must be at least 1");
    end

    // A bit moves only when stages two and three agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s1_reg <= RESET_VAL;
            s2_reg <= RESET_VAL;
            s3_reg <= RESET_VAL;
            out_reg <= RESET_VAL;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign pin_out = out_reg;
endmodule : pin_sync3

// file: verification/supply_model.sv
// Power supply model driving the three active-low power-fail pins
`timescale 1ns/1ps
module supply_model (
    input wire logic sys_clk,
    input wire logic fail,
    input wire logic protect,
    input wire logic restart_ack,
    output logic power_fail_irq_n,
    output logic mem_protect_n,
    output logic power_fail_sense_n
);
    logic sense_reg = 1'b0;

    // Sense stays set after restore so power-on code can see the failure
    always @(posedge sys_clk) begin
        if (fail) begin
            sense_reg <= 1'b1;
        end else if (restart_ack) begin
            sense_reg <= 1'b0;
        end
    end

    always_comb power_fail_irq_n = ~fail;
    always_comb mem_protect_n = ~protect;
    always_comb power_fail_sense_n = ~sense_reg;
endmodule : supply_model

// file: verification/tb.sv
// Self-checking bench for the board decode and power-fail block
`timescale 1ns/1ps
module tb;
    import board_decode_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [19:0] cpu_addr = 20'h00000;
    logic cpu_bhe_n = 1'b1, cpu_mem_rd = 1'b0, cpu_mem_wr = 1'b0, cpu_io_rd = 1'b0, cpu_io_wr = 1'b0;
    logic [7:0] cpu_io_wdata = 8'h00;
    logic bus_ram_rd = 1'b0, bus_ram_wr = 1'b0, bus_bhe_n = 1'b1, bus_a0 = 1'b0;
    logic exp0_present = 1'b1, exp1_present = 1'b1, nmi_route_en = 1'b1;
    logic fail = 1'b0, protect = 1'b0, restart_ack = 1'b0;
    wire logic power_fail_irq_n, mem_protect_n, power_fail_sense_n;
    wire logic [1:0] rom_bank_sel, rom_lane_en, ram_lane_en;
    wire logic [12:0] rom_dev_addr;
    wire logic ram_local_rd, ram_local_wr, ram_bus_rd, ram_bus_wr;
    io_target_t io_target;
    wire logic io_rd_strobe, io_wr_strobe, io_offboard, nmi_req, nmi_mask, power_fail_seen;
    int err_total = 0;
    int cmp_count = 0;

    always #12.5 sys_clk = ~sys_clk;

    supply_model psu (.sys_clk(sys_clk), .fail(fail), .protect(protect), .restart_ack(restart_ack),
        .power_fail_irq_n(power_fail_irq_n), .mem_protect_n(mem_protect_n),
        .power_fail_sense_n(power_fail_sense_n));

    board_decode_powerfail #(.ROM_DEV_ABITS(13)) dut (.sys_clk(sys_clk), .rst(rst), .cpu_addr(cpu_addr),
        .cpu_bhe_n(cpu_bhe_n), .cpu_mem_rd(cpu_mem_rd), .cpu_mem_wr(cpu_mem_wr), .cpu_io_rd(cpu_io_rd),
        .cpu_io_wr(cpu_io_wr), .cpu_io_wdata(cpu_io_wdata), .bus_ram_rd(bus_ram_rd), .bus_ram_wr(bus_ram_wr),
        .bus_bhe_n(bus_bhe_n), .bus_a0(bus_a0), .exp0_present(exp0_present), .exp1_present(exp1_present),
        .nmi_route_en(nmi_route_en), .power_fail_irq_n(power_fail_irq_n), .mem_protect_n(mem_protect_n),
        .power_fail_sense_n(power_fail_sense_n), .rom_bank_sel(rom_bank_sel), .rom_lane_en(rom_lane_en),
        .rom_dev_addr(rom_dev_addr), .ram_local_rd(ram_local_rd), .ram_local_wr(ram_local_wr),
        .ram_bus_rd(ram_bus_rd), .ram_bus_wr(ram_bus_wr), .ram_lane_en(ram_lane_en), .io_target(io_target),
        .io_rd_strobe(io_rd_strobe), .io_wr_strobe(io_wr_strobe), .io_offboard(io_offboard),
        .nmi_req(nmi_req), .nmi_mask(nmi_mask), .power_fail_seen(power_fail_seen));

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : tick

    task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    task automatic rom_case(input logic [19:0] a, input logic bhe_n, input logic [1:0] bank,
                            input logic [1:0] lanes, input logic [12:0] dev);
        cpu_addr = a;
        cpu_bhe_n = bhe_n;
        tick(1);
        chk("rom_bank_sel", bank, rom_bank_sel);
        chk("rom_lane_en", lanes, rom_lane_en);
        chk("rom_dev_addr", dev, rom_dev_addr);
    endtask : rom_case

    // Both banks are populated here, so bank 0 space may be read
    task automatic test_rom;
        cpu_mem_rd = 1'b1;
        rom_case(20'hFFFF0, 1'b0, 2'b10, 2'b11, 13'h1FF8);
        rom_case(20'hFFFFF, 1'b0, 2'b10, 2'b10, 13'h1FFF);
        rom_case(20'hFC000, 1'b1, 2'b10, 2'b01, 13'h0000);
        rom_case(20'hFBFFE, 1'b0, 2'b01, 2'b11, 13'h1FFF);
        rom_case(20'hF8006, 1'b1, 2'b01, 2'b01, 13'h0003);
        rom_case(20'hF7FFE, 1'b0, 2'b00, 2'b00, 13'h1FFF);
        cpu_mem_rd = 1'b0;
        tick(1);
        chk("rom_lane_en idle", 2'b00, rom_lane_en);
        $display("test rom done");
    endtask : test_rom

    task automatic io_case(input logic [7:0] port, input io_target_t exp);
        cpu_addr = {12'h000, port};
        tick(1);
        chk("io_target", exp, io_target);
        chk("io_offboard", exp == IO_OFFBOARD, io_offboard);
        chk("io_rd_strobe", 1'b1, io_rd_strobe);
    endtask : io_case

    task automatic test_io;
        cpu_io_rd = 1'b1;
        io_case(8'hC0, IO_PIC);
        io_case(8'hC6, IO_PIC);
        io_case(8'hCE, IO_PPI);
        io_case(8'hD0, IO_TIMER);
        io_case(8'hDA, IO_SERIAL);
        io_case(8'hCB, IO_STATUS);
        io_case(8'hC1, IO_OFFBOARD);
        io_case(8'h00, IO_OFFBOARD);
        io_case(8'hA1, IO_EXP0);
        io_case(8'hBE, IO_EXP0);
        io_case(8'h8F, IO_EXP1);
        io_case(8'h9E, IO_EXP1);
        io_case(8'h9F, IO_OFFBOARD);
        exp0_present = 1'b0;
        exp1_present = 1'b0;
        io_case(8'hA0, IO_OFFBOARD);
        io_case(8'h84, IO_OFFBOARD);
        cpu_io_rd = 1'b0;
        exp0_present = 1'b1;
        exp1_present = 1'b1;
        tick(1);
        chk("io_target idle", IO_OFFBOARD, io_target);
        $display("test io done");
    endtask : test_io

    task automatic status_write(input logic [7:0] port, input logic [7:0] data);
        cpu_addr = {12'h000, port};
        cpu_io_wdata = data;
        cpu_io_wr = 1'b1;
        tick(1);
        chk("io_wr_strobe", 1'b1, io_wr_strobe);
        chk("nmi_mask", data[2], nmi_mask);
        cpu_io_wr = 1'b0;
        tick(1);
    endtask : status_write

    task automatic test_nmi;
        fail = 1'b1;
        tick(8);
        chk("nmi_req masked", 1'b0, nmi_req);
        status_write(8'hC9, 8'h04);
        chk("nmi_req open", 1'b1, nmi_req);
        nmi_route_en = 1'b0;
        tick(2);
        chk("nmi_req unrouted", 1'b0, nmi_req);
        nmi_route_en = 1'b1;
        tick(2);
        chk("nmi_req rerouted", 1'b1, nmi_req);
        status_write(8'hDF, 8'hFB);
        chk("nmi_req remasked", 1'b0, nmi_req);
        status_write(8'hD3, 8'h04);
        fail = 1'b0;
        tick(8);
        chk("nmi_req released", 1'b0, nmi_req);
        $display("test nmi done");
    endtask : test_nmi

    task automatic test_protect;
        cpu_addr = 20'h00100;
        cpu_bhe_n = 1'b0;
        cpu_mem_wr = 1'b1;
        bus_ram_wr = 1'b1;
        tick(1);
        chk("ram_local_wr", 1'b1, ram_local_wr);
        chk("ram_bus_wr", 1'b1, ram_bus_wr);
        chk("ram_lane_en", 2'b11, ram_lane_en);
        protect = 1'b1;
        tick(8);
        chk("ram_local_wr prot", 1'b0, ram_local_wr);
        chk("ram_bus_wr prot", 1'b0, ram_bus_wr);
        chk("ram_lane_en prot", 2'b00, ram_lane_en);
        {cpu_mem_wr, bus_ram_wr, cpu_mem_rd, bus_ram_rd} = 4'h3;
        tick(1);
        chk("ram rd prot", 2'b00, {ram_local_rd, ram_bus_rd});
        protect = 1'b0;
        tick(8);
        chk("ram rd open", 2'b11, {ram_local_rd, ram_bus_rd});
        // Bus-only write, high lane, so the bus lanes are not masked by a local cycle
        {cpu_mem_rd, bus_ram_rd, bus_ram_wr} = 3'b001;
        bus_bhe_n = 1'b0;
        bus_a0 = 1'b1;
        tick(1);
        chk("ram_bus_wr alone", 1'b1, ram_bus_wr);
        chk("ram_local_wr idle", 1'b0, ram_local_wr);
        chk("ram_lane_en bus hi", 2'b10, ram_lane_en);
        bus_ram_wr = 1'b0;
        tick(1);
        chk("ram_lane_en idle", 2'b00, ram_lane_en);
        $display("test protect done");
    endtask : test_protect

    task automatic test_sense;
        tick(4);
        chk("power_fail_seen held", 1'b1, power_fail_seen);
        restart_ack = 1'b1;
        tick(8);
        chk("power_fail_seen cleared", 1'b0, power_fail_seen);
        restart_ack = 1'b0;
        $display("test sense done");
    endtask : test_sense

    initial begin
        #(25 * 3000);
        err_total++;
        close_out();
    end

    initial begin
        tick(12);
        rst = 1'b0;
        tick(1);
        chk("nmi_mask reset", 1'b0, nmi_mask);
        test_rom();
        test_io();
        test_nmi();
        test_protect();
        test_sense();
        close_out();
    end
endmodule : tb
